// [core/pps_disc_pkg.sv]
package pps_disc_pkg;
	// Clocks: core clock and the 10 MHz reference grid it emulates
	localparam int CLK_HZ = 200_000_000;
	localparam int REF_HZ = 10_000_000;
	localparam int DIV10 = CLK_HZ / REF_HZ;
	localparam int PPS_DIV_DEF = 10_000_000;
	localparam int PPS_HIGH_DEF = 1_000_000;
	localparam int REF_WAIT_DEF = 11_000_000;
	// Phase meter reports in 100 ps units but counts 5 ns clock steps, coarser than the 400 ps needed
	localparam int RES_PS = 400;
	localparam int STEP_PS = 100;
	localparam int CLK_PS = 1_000_000_000 / (CLK_HZ / 1000);
	localparam int CLK_UNITS = CLK_PS / STEP_PS;
	localparam int GOOD_NS = 20;
	localparam int RESYNC_NS = 1000;
	localparam int CABLE_NS = 100;
	localparam logic signed [35:0] GOOD_U = 36'(GOOD_NS * 1000 / STEP_PS);
	localparam logic signed [35:0] RESYNC_U = 36'(RESYNC_NS * 1000 / STEP_PS);
	localparam logic signed [15:0] CABLE_MAX = 16'(CABLE_NS * 1000 / STEP_PS);
	localparam logic [15:0] TAU_MIN = 16'h000A;
	localparam logic [15:0] TAU_MAX = 16'h2710;
	localparam logic [15:0] TAU_RST = 16'h000A;
	// Register byte addresses
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_TAU = 8'h04;
	localparam logic [7:0] A_CABLE = 8'h08;
	localparam logic [7:0] A_STAT = 8'h0C;
	localparam logic [7:0] A_PHASE = 8'h10;
	localparam logic [7:0] A_TOD = 8'h14;
	localparam logic [7:0] A_TODV = 8'h18;
	localparam logic [7:0] A_TODC = 8'h1C;
	localparam logic [7:0] A_FREQ = 8'h20;
	// Control bits
	localparam int B_DISC = 0;
	localparam int B_AUTO = 1;
	localparam int B_SYNC = 2;
	localparam int B_SAVE = 3;
	localparam int B_LOAD = 0;
	localparam int B_ADD = 1;
	localparam logic [1:0] OKAY = 2'h0;
	localparam logic [1:0] SLVERR = 2'h2;

	typedef enum logic [1:0] {
		ST_OFF   = 2'h0,
		ST_INIT  = 2'h1,
		ST_TRACK = 2'h3,
		ST_HOLD  = 2'h2
	} disc_state_t;

	typedef struct packed {
		logic [7:0]  awaddr;
		logic        awvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        wvalid;
		logic        bready;
		logic [7:0]  araddr;
		logic        arvalid;
		logic        rready;
	} axil_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic [1:0]  bresp;
		logic        bvalid;
		logic        arready;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        rvalid;
	} axil_rsp_t;
endpackage : pps_disc_pkg

// [core/pps_discipline.sv]
`timescale 1ns/1ps
// Summary of operation
// [RL1] Phase between own and reference pulse measured every second, 400 ps or finer; here counted in 5 ns core clock steps.
// [RL2] While disciplining, each measurement steers frequency correction toward phase and frequency.
// [RL3] Discipline enable and time constant restored from and saved to non-volatile store.
// [RL4] Time constant accepted in seconds, clamped to 10..10000.
// [RL5] Before steering, servo state is cleared and output pulse resynced to reference.
// [RL6] Init on enable, and on lock reached while already enabled.
// [RL7] Lost reference enters holdover, frequency correction frozen.
// [RL8] Reference return resumes servo; beyond 1 us offset a resync first.
// [RL9] Disable then enable gives a full servo reinitialisation.
// [RL10] Latest phase reported in whole ns, own minus reference, early reads negative.
// [RL11] Quality 0 at start, 1 after 2 tau under 20 ns, 2 in holdover.
// [RL12] Setting autosync or discipline enable clears the other.
// [RL13] Cable value signed in 100 ps steps, clamped to plus or minus 100 ns.
// [RL14] Cable value may be saved to non-volatile store.
// [RL15] New cable value is applied to the latest taken measurement.
// [RL16] Cable value shifts servo target only; reported phase stays raw.
// [RL17] Time of day counts own pulse rising edges from zero.
// [RL18] Time of day read waits for next pulse, then returns N+1.
// [RL19] Time of day may be loaded absolutely or adjusted by signed delta.
// [RL20] Host sets time of day right after a pulse to avoid ambiguity.
// [RL21] Output pulse is the 10 MHz grid divided by ten million.
// [RL22] Sync restarts the dividers at the grid edge nearest the reference edge.
// [RL23] Serial link runs 57600 8N1; carried by the register bus here.
// [RL24] No reference edge within slightly over a second means reference absent.
// [RL25] Phase meter yields a signed result per reference edge.
module pps_discipline
	import pps_disc_pkg::*;
#(
	parameter int PPS_DIV  = PPS_DIV_DEF,
	parameter int PPS_HIGH = PPS_HIGH_DEF,
	parameter int REF_WAIT = REF_WAIT_DEF
) (
	input  wire logic               ref_clk_in,
	input  wire logic               resetn_in,
	input  wire axil_req_t          axi_req_in,
	output axil_rsp_t               axi_rsp_out,
	input  wire logic               ref_pps_in,
	input  wire logic               lock_ok_in,
	input  wire logic               nv_disc_en_in,
	input  wire logic [15:0]        nv_tau_in,
	input  wire logic [15:0]        nv_cable_in,
	output logic                    pps_out,
	output logic signed [39:0]      freq_corr_out,
	output logic                    nv_write_out,
	output logic                    nv_disc_en_out,
	output logic [15:0]             nv_tau_out,
	output logic [15:0]             nv_cable_out
);
	localparam int CYC_PER = PPS_DIV * DIV10;

	function automatic logic [15:0] clamp_tau(input logic [15:0] v);
		clamp_tau = (v < TAU_MIN) ? TAU_MIN : ((v > TAU_MAX) ? TAU_MAX : v);
	endfunction : clamp_tau

	function automatic logic signed [15:0] clamp_cable(input logic signed [15:0] v);
		clamp_cable = (v > CABLE_MAX) ? CABLE_MAX : ((v < -CABLE_MAX) ? -CABLE_MAX : v);
	endfunction : clamp_cable

	function automatic logic [3:0] log2_tau(input logic [15:0] v);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 1; i < 16; i++) begin
			if (v[i]) r = 4'(i);
		end
		log2_tau = r;
	endfunction : log2_tau

	function automatic logic signed [35:0] abs36(input logic signed [35:0] v);
		abs36 = v[35] ? -v : v;
	endfunction : abs36

	disc_state_t             state_q;
	logic                    disc_en_q, auto_en_q, sync_arm_q, save_q, loaded_q;
	logic                    disc_prev_q, lock_prev_q, ref_prev_q;
	logic [15:0]             tau_q;
	logic signed [15:0]      cable_q;
	logic                    cable_new_q;
	logic [4:0]              tick_q;
	logic [23:0]             pps_cnt_q;
	logic [27:0]             cyc_q;
	logic [24:0]             wait_q;
	logic signed [35:0]      phase_q;
	logic signed [39:0]      integ_q, freq_q;
	logic [15:0]             good_q;
	logic [1:0]              quality_q;
	logic [31:0]             tod_q, todv_q;
	logic                    tick, ref_edge, pps_evt, sync_now, lost, big;
	logic signed [35:0]      meas, err;
	logic                    upd;

	// Reference edge and 10 MHz grid enable
	assign ref_edge = ref_pps_in & ~ref_prev_q;
	assign tick = (tick_q == 5'(DIV10 - 1));
	// Signed own-minus-reference; a reference late in the second means own was late
	assign meas = (cyc_q < 28'(CYC_PER / 2)) ? -36'(cyc_q) * 36'(CLK_UNITS) //RL25
		: 36'(28'(CYC_PER) - cyc_q) * 36'(CLK_UNITS); //RL1
	assign big = abs36(meas) > RESYNC_U;
	assign lost = (wait_q >= 25'(REF_WAIT)); //RL24
	// Resync sources: autosync, manual request, init, large holdover slip
	assign sync_now = ref_edge & (auto_en_q | sync_arm_q | (state_q == ST_INIT) //RL5
		| (state_q == ST_HOLD & big)); //RL8
	assign pps_evt = sync_now | (tick & (pps_cnt_q == 24'(PPS_DIV - 1))); //RL21
	// Servo target is offset by cable value; the reported phase is not
	assign err = (upd ? meas : phase_q) + 36'(cable_q); //RL16
	assign upd = ref_edge & ~sync_now & (state_q == ST_TRACK | state_q == ST_HOLD);

	// Edge history
	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			ref_prev_q <= 1'b0;
			lock_prev_q <= 1'b0;
			disc_prev_q <= 1'b0;
		end else begin
			ref_prev_q <= ref_pps_in;
			lock_prev_q <= lock_ok_in;
			disc_prev_q <= disc_en_q;
		end
	end

	// Dividers restart together so the pulse lands on the grid edge at the reference
	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			tick_q <= 5'h00;
			// Start past the high window so reset release gives no false rising edge
			pps_cnt_q <= 24'(PPS_HIGH);
			cyc_q <= 28'h0000000;
			pps_out <= 1'b0;
		end else begin
			if (sync_now) begin
				tick_q <= 5'h00; //RL22
				pps_cnt_q <= 24'h000000;
				cyc_q <= 28'h0000000;
			end else begin
				tick_q <= tick ? 5'h00 : tick_q + 5'h01;
				cyc_q <= pps_evt ? 28'h0000000 : cyc_q + 28'h0000001;
				if (tick) pps_cnt_q <= pps_evt ? 24'h000000 : pps_cnt_q + 24'h000001;
			end
			pps_out <= pps_evt | (pps_cnt_q < 24'(PPS_HIGH) & ~(tick & pps_evt));
		end
	end

	// Reference watchdog in grid ticks
	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) wait_q <= 25'h0000000;
		else if (ref_edge) wait_q <= 25'h0000000;
		else if (tick & ~lost) wait_q <= wait_q + 25'h0000001;
	end

	// Discipline sequencer
	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			state_q <= ST_OFF;
		end else begin
			unique case (state_q)
				ST_OFF:   if (disc_en_q) state_q <= ST_INIT; //RL6
				ST_INIT:  if (!disc_en_q) state_q <= ST_OFF;
					else if (ref_edge) state_q <= ST_TRACK; //RL5
				ST_TRACK: if (!disc_en_q || (disc_en_q && !disc_prev_q)) state_q <= ST_OFF;
					else if (lock_ok_in && !lock_prev_q) state_q <= ST_INIT; //RL6
					else if (lost) state_q <= ST_HOLD; //RL7
				ST_HOLD:  if (!disc_en_q) state_q <= ST_OFF;
					else if (lock_ok_in && !lock_prev_q) state_q <= ST_INIT;
					else if (ref_edge) state_q <= ST_TRACK; //RL8
			endcase
		end
	end

	// Latest measurement, kept raw for reporting
	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) phase_q <= 36'sh0;
		else if (ref_edge & ~sync_now) phase_q <= meas; //RL10
		else if (sync_now) phase_q <= 36'sh0;
	end

	// Proportional-integral steer, gains scaled by the time constant
	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in || state_q == ST_OFF || state_q == ST_INIT) begin
			integ_q <= 40'sh0; //RL5
			freq_q <= 40'sh0; //RL9
		end else if (upd || (cable_new_q && state_q == ST_TRACK)) begin
			integ_q <= integ_q - (40'(err) >>> (2 * log2_tau(tau_q))); //RL2
			freq_q <= integ_q - (40'(err) >>> log2_tau(tau_q)); //RL15
		end
	end
	assign freq_corr_out = freq_q; // Frozen outside updates, which gives holdover //RL7

	// Quality indicator
	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in || state_q == ST_OFF || state_q == ST_INIT) begin
			good_q <= 16'h0000;
			quality_q <= 2'h0; //RL11
		end else if (state_q == ST_HOLD) begin
			quality_q <= 2'h2; //RL11
		end else begin
			if (upd) good_q <= (abs36(meas) < GOOD_U) ? good_q + 16'h0001 : 16'h0000;
			quality_q <= (good_q >= {tau_q[14:0], 1'b0}) ? 2'h1 : 2'h0; //RL11
		end
	end

	// Time of day: advanced by each own pulse except one that coincides with a host load or add, which then wins
	logic wr_fire;
	logic [7:0] wa_q;
	logic [31:0] wd_q;
	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) tod_q <= 32'h00000000; //RL17
		else if (wr_fire && wa_q == A_TODC && wd_q[B_LOAD]) tod_q <= todv_q; //RL19
		else if (wr_fire && wa_q == A_TODC && wd_q[B_ADD]) tod_q <= tod_q + todv_q; //RL19
		else if (pps_evt) tod_q <= tod_q + 32'h00000001; //RL17
	end

	// AXI4-Lite write side: address and data taken in either order
	logic aw_q, w_q, bvalid_q, berr_q;
	assign wr_fire = aw_q & w_q & ~bvalid_q;
	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			bvalid_q <= 1'b0;
			berr_q <= 1'b0;
			wa_q <= 8'h00;
			wd_q <= 32'h00000000;
		end else begin
			if (axi_req_in.awvalid && axi_rsp_out.awready) begin
				aw_q <= 1'b1;
				wa_q <= axi_req_in.awaddr;
			end
			if (axi_req_in.wvalid && axi_rsp_out.wready) begin
				w_q <= 1'b1;
				for (int b = 0; b < 4; b++) begin
					wd_q[8*b +: 8] <= axi_req_in.wstrb[b] ? axi_req_in.wdata[8*b +: 8] : 8'h00;
				end
			end
			if (wr_fire) begin
				aw_q <= 1'b0;
				w_q <= 1'b0;
				bvalid_q <= 1'b1;
				berr_q <= !(wa_q inside {A_CTRL, A_TAU, A_CABLE, A_TODV, A_TODC});
			end else if (axi_req_in.bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// Writable state; non-volatile copies are taken once after reset release
	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			loaded_q <= 1'b0;
			disc_en_q <= 1'b0;
			auto_en_q <= 1'b0;
			sync_arm_q <= 1'b0;
			save_q <= 1'b0;
			tau_q <= TAU_RST;
			cable_q <= 16'sh0;
			cable_new_q <= 1'b0;
			todv_q <= 32'h00000000;
			nv_write_out <= 1'b0;
		end else begin
			cable_new_q <= 1'b0;
			nv_write_out <= 1'b0;
			if (ref_edge) sync_arm_q <= 1'b0;
			if (!loaded_q) begin
				loaded_q <= 1'b1;
				disc_en_q <= nv_disc_en_in; //RL3
				tau_q <= clamp_tau(nv_tau_in);
				cable_q <= clamp_cable(nv_cable_in);
			end else if (wr_fire) begin
				unique case (wa_q)
					A_CTRL: begin
						disc_en_q <= wd_q[B_DISC]; //RL12
						auto_en_q <= wd_q[B_AUTO] & ~wd_q[B_DISC]; //RL12
						if (wd_q[B_SYNC]) sync_arm_q <= 1'b1;
						save_q <= wd_q[B_SAVE];
						nv_write_out <= 1'b1; //RL3
					end
					A_TAU: begin
						tau_q <= clamp_tau(wd_q[15:0]); //RL4
						nv_write_out <= 1'b1;
					end
					A_CABLE: begin
						cable_q <= clamp_cable(wd_q[15:0]); //RL13
						cable_new_q <= 1'b1; //RL15
						nv_write_out <= save_q; //RL14
					end
					A_TODV: todv_q <= wd_q;
					default: ;
				endcase
			end
		end
	end
	assign nv_disc_en_out = disc_en_q;
	assign nv_tau_out = tau_q;
	assign nv_cable_out = cable_q;

	// AXI4-Lite read side; a time of day read is held until the next pulse
	logic ar_q, rvalid_q;
	logic [7:0] ra_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic signed [35:0] ns_r;
	assign ns_r = (phase_q + (phase_q[35] ? -36'sd5 : 36'sd5)) / 36'sd10; //RL10
	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			ar_q <= 1'b0;
			ra_q <= 8'h00;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= OKAY;
		end else begin
			if (axi_req_in.arvalid && axi_rsp_out.arready) begin
				ar_q <= 1'b1;
				ra_q <= axi_req_in.araddr;
			end
			if (rvalid_q && axi_req_in.rready) rvalid_q <= 1'b0;
			if (ar_q && (ra_q != A_TOD || pps_evt)) begin
				ar_q <= 1'b0;
				rvalid_q <= 1'b1;
				rresp_q <= OKAY;
				unique case (ra_q)
					A_CTRL:  rdata_q <= {28'h0, save_q, sync_arm_q, auto_en_q, disc_en_q};
					A_TAU:   rdata_q <= {16'h0000, tau_q};
					A_CABLE: rdata_q <= {{16{cable_q[15]}}, cable_q};
					A_STAT:  rdata_q <= {26'h0, lost, lock_ok_in, state_q, quality_q};
					A_PHASE: rdata_q <= ns_r[31:0];
					A_TOD:   rdata_q <= tod_q + 32'h00000001; //RL18
					A_TODV:  rdata_q <= todv_q;
					A_FREQ:  rdata_q <= freq_q[31:0];
					default: begin
						rdata_q <= 32'h00000000;
						rresp_q <= SLVERR;
					end
				endcase
			end
		end
	end

	always_comb begin
		axi_rsp_out.awready = ~aw_q & ~bvalid_q;
		axi_rsp_out.wready = ~w_q & ~bvalid_q;
		axi_rsp_out.bvalid = bvalid_q;
		axi_rsp_out.bresp = berr_q ? SLVERR : OKAY;
		axi_rsp_out.arready = ~ar_q & ~rvalid_q;
		axi_rsp_out.rvalid = rvalid_q;
		axi_rsp_out.rdata = rdata_q;
		axi_rsp_out.rresp = rresp_q;
	end

	// Checks
	sequence s_tod_wait;
		ar_q && ra_q == A_TOD && !pps_evt;
	endsequence
	AST_TAU_RANGE: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		loaded_q |-> tau_q >= TAU_MIN && tau_q <= TAU_MAX) //RL4
		else $error("tau out of range");
	AST_CABLE_RANGE: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		cable_q <= CABLE_MAX && cable_q >= -CABLE_MAX) //RL13
		else $error("cable out of range");
	AST_EXCL: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		!(disc_en_q && auto_en_q)) //RL12
		else $error("autosync and discipline both on");
	AST_HOLD_FREEZE: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		state_q == ST_HOLD && !ref_edge ##1 state_q == ST_HOLD |-> $stable(freq_q)) //RL7
		else $error("steer moved in holdover");
	AST_HOLD_QUAL: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		state_q == ST_HOLD ##1 state_q == ST_HOLD |-> quality_q == 2'h2) //RL11
		else $error("quality not 2 in holdover");
	AST_TOD_INC: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		pps_evt && !wr_fire |=> tod_q == $past(tod_q) + 32'h00000001) //RL17
		else $error("time of day missed a pulse");
	AST_TOD_HOLD: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		s_tod_wait |=> !rvalid_q || $past(rvalid_q)) //RL18
		else $error("time of day answered before pulse");
	AST_SYNC_PPS: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		sync_now |=> pps_out && cyc_q == 28'h0000000 ##1 cyc_q == 28'h0000001) //RL22
		else $error("sync did not restart divider");
	AST_INIT_CLEAR: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		state_q == ST_INIT |=> freq_q == 40'sh0 && integ_q == 40'sh0) //RL5
		else $error("servo not cleared at init");
	AST_LOST: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		state_q == ST_TRACK && lost && disc_en_q && disc_prev_q && !(lock_ok_in && !lock_prev_q)
		|=> state_q == ST_HOLD) //RL24
		else $error("no holdover on lost reference");
endmodule : pps_discipline

// [testbench/pps_discipline_and_time_of_day_test.sv]
`timescale 1ns/1ps
module pps_discipline_and_time_of_day_test import pps_disc_pkg::*;;
	logic        clk, resetn, ref_en, ref_hold, lock_ok, ref_pps, pps, nv_wr, pps_d;
	axil_req_t   req;
	axil_rsp_t   rsp;
	logic [15:0] nv_tau, nv_cable;
	logic [31:0] d, p0, f0;
	logic [1:0]  r;
	logic        nv_den, nv_den_o;
	logic [15:0] nv_tau_i, nv_cable_i;
	logic [39:0] fcorr;
	int          fails, n_compared, cyc, pps_cnt, nv_cnt, period, last_rise, k;
	logic [31:0] cw [4] = '{32'h2, 32'h1, 32'h2, 32'h3};
	logic [31:0] ce [4] = '{32'h2, 32'h1, 32'h2, 32'h1};

	pps_discipline #(.PPS_DIV(50), .PPS_HIGH(10), .REF_WAIT(55)) u_dut (
		.ref_clk_in(clk), .resetn_in(resetn), .axi_req_in(req), .axi_rsp_out(rsp),
		.ref_pps_in(ref_pps), .lock_ok_in(lock_ok), .nv_disc_en_in(nv_den),
		.nv_tau_in(nv_tau_i), .nv_cable_in(nv_cable_i), .pps_out(pps), .freq_corr_out(fcorr),
		.nv_write_out(nv_wr), .nv_disc_en_out(nv_den_o), .nv_tau_out(nv_tau),
		.nv_cable_out(nv_cable));
	ref_pps_source #(.PERIOD(1000), .HIGH(100)) u_ref (
		.clk_in(clk), .en_in(ref_en), .hold_in(ref_hold), .pps_out(ref_pps));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Pulse edges, periods and store requests seen at the ports
	always @(posedge clk) begin
		cyc <= cyc + 1;
		pps_d <= pps;
		if (nv_wr === 1'b1) nv_cnt <= nv_cnt + 1;
		if (pps === 1'b1 && pps_d === 1'b0) begin
			pps_cnt <= pps_cnt + 1;
			period <= cyc - last_rise;
			last_rise <= cyc;
		end
	end
	// Hang guard, sized well above the planned run
	initial begin
		repeat (60000) @(posedge clk);
		fails++;
		$display("CHECK FAILED at %0t: timeout", $time);
		test_done();
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: %s got %h want %h", $time, msg, seen, exp);
		end
	endtask : chk
	// Ready and valid are taken at the rising edge where the transfer happens
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic tb;
		tb = 1'b0;
		@(posedge clk);
		req.awaddr <= a; req.awvalid <= 1'b1; req.wdata <= v;
		req.wstrb <= 4'hF; req.wvalid <= 1'b1; req.bready <= 1'b1;
		while (!tb) begin
			@(posedge clk);
			if (rsp.awready) req.awvalid <= 1'b0;
			if (rsp.wready) req.wvalid <= 1'b0;
			tb = rsp.bvalid;
			r = rsp.bresp;
			if (tb) req.bready <= 1'b0;
		end
	endtask : wr
	task automatic rd(input logic [7:0] a);
		logic tr;
		tr = 1'b0;
		@(posedge clk);
		req.araddr <= a; req.arvalid <= 1'b1; req.rready <= 1'b1;
		while (!tr) begin
			@(posedge clk);
			if (rsp.arready) req.arvalid <= 1'b0;
			tr = rsp.rvalid;
			d = rsp.rdata;
			r = rsp.rresp;
			if (tr) req.rready <= 1'b0;
		end
	endtask : rd
	task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
		input string msg);
		rd(a);
		chk(d & m, e, msg);
	endtask : rdc
	task automatic test_done();
		$display("compared %0d, failed %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : test_done

	// Main sequence; one second is 1000 clocks at the shortened divider
	initial begin
		resetn = 1'b0; ref_en = 1'b1; ref_hold = 1'b0; lock_ok = 1'b1; req = '0;
		fails = 0; n_compared = 0; cyc = 0; pps_cnt = 0; nv_cnt = 0;
		period = 0; last_rise = 0; pps_d = 1'b0;
		nv_den = 1'b0; nv_tau_i = 16'h0005; nv_cable_i = 16'h0FA0;
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		repeat (2) @(posedge clk);
		rdc(A_TAU, 32'hFFFFFFFF, 32'h0000000A, "tau load");
		rdc(A_CABLE, 32'h0000FFFF, 32'h000003E8, "cable load");
		rdc(A_STAT, 32'h0000000F, 32'h00000000, "start status");
		rdc(8'h40, 32'hFFFFFFFF, 32'h00000000, "unmapped data");
		chk({30'h0, r}, {30'h0, SLVERR}, "unmapped resp");
		wr(A_STAT, 32'h00000001);
		chk({30'h0, r}, {30'h0, SLVERR}, "ro write resp");
		$display("test reset done");
		wr(A_TAU, 32'h00004E20);
		rdc(A_TAU, 32'hFFFFFFFF, 32'h00002710, "tau clamp");
		chk({16'h0, nv_tau}, 32'h00002710, "tau store");
		wr(A_CABLE, 32'hFFFFFA24);
		rdc(A_CABLE, 32'h0000FFFF, 32'h0000FC18, "cable clamp");
		for (int i = 0; i < 4; i++) begin
			wr(A_CTRL, cw[i]);
			rdc(A_CTRL, 32'h00000003, ce[i], "mode exclusive");
		end
		wr(A_CTRL, 32'h00000000);
		$display("test registers done");
		repeat (3) @(posedge pps);
		repeat (2) @(posedge clk);
		chk(period, 32'd1000, "pulse period");
		rd(A_TOD);
		repeat (2) @(posedge clk);
		chk(d, pps_cnt, "tod count");
		wr(A_TODV, 32'd100);
		wr(A_TODC, 32'h00000001);
		rdc(A_TOD, 32'hFFFFFFFF, 32'd101, "tod load");
		wr(A_TODV, 32'hFFFFFFFB);
		wr(A_TODC, 32'h00000002);
		rdc(A_TOD, 32'hFFFFFFFF, 32'd97, "tod add");
		$display("test time of day done");
		wr(A_CTRL, 32'h00000009);
		chk({31'h0, nv_den_o}, 32'h1, "enable store");
		repeat (3000) @(posedge clk);
		rdc(A_STAT, 32'h0000000C, 32'h0000000C, "tracking");
		rd(A_PHASE);
		p0 = d;
		chk({31'h0, $signed(p0) <= 50 && $signed(p0) >= -50}, 32'h1, "init sync");
		rd(A_FREQ);
		f0 = d;
		ref_hold <= 1'b1;
		repeat (40) @(posedge clk);
		ref_hold <= 1'b0;
		repeat (2000) @(posedge clk);
		rdc(A_PHASE, 32'hFFFFFFFF, p0 - 32'd200, "phase sign");
		rd(A_FREQ);
		chk({31'h0, d !== f0}, 32'h1, "steering");
		k = nv_cnt;
		f0 = d;
		wr(A_CABLE, 32'h000001F4);
		rdc(A_PHASE, 32'hFFFFFFFF, p0 - 32'd200, "phase raw");
		rd(A_FREQ);
		chk({31'h0, d !== f0}, 32'h1, "cable applied");
		chk({16'h0, nv_cable}, 32'h000001F4, "cable store");
		chk(nv_cnt, k + 1, "cable save pulse");
		$display("test discipline done");
		lock_ok <= 1'b0;
		repeat (3) @(posedge clk);
		lock_ok <= 1'b1;
		repeat (3) @(posedge clk);
		rdc(A_STAT, 32'h0000000C, 32'h00000004, "lock reinit");
		repeat (3000) @(posedge clk);
		ref_en <= 1'b0;
		repeat (2500) @(posedge clk);
		rdc(A_STAT, 32'h0000003F, 32'h0000003A, "holdover");
		rd(A_FREQ);
		f0 = d;
		repeat (1000) @(posedge clk);
		rdc(A_FREQ, 32'hFFFFFFFF, f0, "frozen");
		chk(fcorr[31:0], f0, "correction port");
		ref_hold <= 1'b1;
		repeat (300) @(posedge clk);
		ref_hold <= 1'b0;
		ref_en <= 1'b1;
		repeat (3000) @(posedge clk);
		rdc(A_STAT, 32'h0000002C, 32'h0000000C, "resume");
		rdc(A_PHASE, 32'hFFFFFFFF, p0, "resync");
		wr(A_CTRL, 32'h00000000);
		rdc(A_STAT, 32'h0000000C, 32'h00000000, "off");
		wr(A_CTRL, 32'h00000001);
		rdc(A_STAT, 32'h0000000C, 32'h00000004, "reinit");
		$display("test holdover done");
		test_done();
	end
endmodule : pps_discipline_and_time_of_day_test

// [testbench/ref_pps_source.sv]
`timescale 1ns/1ps
// Reference pulse source: one pulse per PERIOD clocks, line low when absent
module ref_pps_source #(
	parameter int PERIOD = 1000,
	parameter int HIGH   = 100
) (
	input  wire logic clk_in,
	input  wire logic en_in,
	input  wire logic hold_in,
	output logic      pps_out
);
	int   cnt = 0;
	logic act = 1'b0;
	// Hold pauses the counter while high, shifting every later edge
	always @(posedge clk_in) begin
		if (!hold_in) cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
		// Enable only takes effect between pulses so no runt edge appears
		if (cnt == PERIOD - 1) act <= en_in;
	end
	// Absent reference reads as a steady low, like a terminated input
	assign pps_out = act && (cnt < HIGH);
endmodule : ref_pps_source
